// >>> tb.sv
/* self-checking bench for the two-wire slave: a master model drives the bus,
   software actions come from tasks here. assumes pull-ups on both lines. */
`timescale 1ns/1ps
module tb;
    logic ref_clk_in = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n_in = 1'b0;
    two_wire_slave_pkg::ctrl_t ctrl = '0;
    two_wire_slave_pkg::clr_t clr = '0;
    logic cmd_valid = 1'b0;
    logic sleep = 1'b0;
    logic done_cmd = 1'b0;
    logic scl_o, sda_o;
    logic [1:0] cmd = 2'h0;
    logic dwr = 1'b0;
    logic [7:0] dreg = 8'h00;
    two_wire_slave_pkg::status_t st;
    logic [7:0] rx_data, r;
    logic [6:0] own;
    logic scl_oe, sda_oe, m_scl, m_sda, a;
    logic [7:0] q[$];
    int failures = 0;
    int checks_done = 0;
    wire scl_line = m_scl & ~scl_oe;
    wire sda_line = m_sda & ~sda_oe;
    initial begin
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        #3.1;
        forever #7.5 link_clk = ~link_clk;
    end
    two_wire_slave_interface uut (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .scl_clk_in(scl_line),
        .sda_in(sda_line), .ctrl_in(ctrl), .clr_in(clr), .sleep_in(sleep),
        .cmd_valid_in(cmd_valid), .slave_command_field_in(cmd), .data_write_in(dwr),
        .slave_data_register_in(dreg), .status_out(st), .rx_data_out(rx_data),
        .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_out(sda_o), .sda_oe_out(sda_oe)
    );
    two_wire_master_model m (
        .link_clk_in(link_clk), .scl_in(scl_line), .sda_in(sda_line),
        .scl_drv_out(m_scl), .sda_drv_out(m_sda)
    );
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : tick
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict
    task automatic wait_flag(input logic dat);
        int n;
        for (n = 0; n < 3000 && (dat ? st.data_event_flag : st.address_stop_event_flag) !== 1'b1;
             n++) tick(1);
        if (n == 3000) begin
            chk("flag wait", 8'h01, 8'h00);
            give_verdict();
        end
        tick(2);
        chk("scl hold", 8'h01, {7'h00, scl_oe});
        chk("hold flag", 8'h01, {7'h00, st.clock_hold_indicator});
    endtask : wait_flag
    // svc: 0 none, 1 address flag, 2 write data flag, 3 read data request
    task automatic mbyte(input logic [7:0] tx, input logic ai, input int svc, input logic nk,
                         input logic [7:0] d, output logic [7:0] rx, output logic ao);
        fork
            m.xfer(tx, ai, rx, ao);
            if (svc != 0) begin
                wait_flag(svc > 1);
                if (svc == 1) chk("direction", {7'h00, tx[0]}, {7'h00, st.dir_read});
                if (svc == 2) chk("rx byte", q.pop_front(), rx_data);
                ctrl.ack_action = nk;
                dreg = d;
                cmd = (nk || done_cmd) ? 2'h2 : 2'h3;
                dwr = (svc == 3);
                cmd_valid = (svc != 3);
                tick(1);
                cmd_valid = 1'b0;
                dwr = 1'b0;
                // scl_oe drops one edge after the flags
                tick(2);
                chk("released", 8'h00, {4'h0, st.data_event_flag, st.address_stop_event_flag,
                    st.clock_hold_indicator, scl_oe});
            end
        join
    endtask : mbyte
    task automatic finish_txn(input logic mt);
        tick(8);
        // by_stop keeps the last stop mark until the next address match
        chk("stop flag", {6'h00, mt, 1'b1}, {6'h00, st.address_stop_event_flag, st.by_stop});
        clr = '1;
        tick(1);
        clr = '0;
        tick(1);
        chk("cleared", 8'h00, {4'h0, st.address_stop_event_flag, st.collision, st.bus_error,
            scl_oe});
    endtask : finish_txn
    initial begin
        logic [7:0] adr[4];
        logic mt;
        void'($urandom(32'h140edb0e));
        own = 7'h01 + 7'($urandom % 63);
        ctrl.own_addr = own;
        ctrl.enable = 1'b1;
        ctrl.stop_ie = 1'b1;
        tick(12);
        rst_n_in = 1'b1;
        tick(4);
        adr = '{{own, 1'b0}, {own ^ 7'h40, 1'b0}, 8'h00, {own ^ 7'h20, 1'b0}};
        for (int i = 0; i < 4; i++) begin
            ctrl.promisc = (i == 3);
            sleep = (i == 1);
            mt = (adr[i][7:1] == own) || adr[i] == 8'h00 || ctrl.promisc;
            m.start();
            mbyte(adr[i], 1'b1, mt, 1'b0, 8'h00, r, a);
            chk("addr ack", {7'h00, ~mt}, {7'h00, a});
            if (mt) begin
                q.push_back(8'($urandom));
                done_cmd = (i == 3);
                mbyte(q[0], 1'b1, 2, i == 2, 8'h00, r, a);
                done_cmd = 1'b0;
                chk("data ack", {7'h00, i == 2}, {7'h00, a});
                if (i == 0) begin
                    m.restart();
                    mbyte(adr[0], 1'b1, 1, 1'b0, 8'h00, r, a);
                    chk("restart ack", 8'h00, {7'h00, a});
                end
            end
            m.stop();
            finish_txn(mt);
        end
        ctrl.promisc = 1'b0;
        // second pass jams sda low against a one to provoke a collision
        for (int t = 0; t < 2; t++) begin
            m.start();
            mbyte({own, 1'b1}, 1'b1, 1, 1'b0, 8'h00, r, a);
            chk("read ack", 8'h00, {7'h00, a});
            for (int i = t; i < 2; i++) begin
                q.push_back(t ? 8'hff : 8'($urandom));
                mbyte(t ? 8'h00 : 8'hff, i == 1, 3, 1'b0, q[0], r, a);
                // collision pass: the master pulls every bit low
                chk("tx byte", t ? 8'h00 : q[0], r);
                void'(q.pop_front());
            end
            m.stop();
            tick(4);
            // rx_nack keeps the last master answer, the nack of the first pass
            chk("end state", {5'h00, 1'b1, 1'b0, t[0]}, {5'h00, st.rx_nack, st.data_event_flag,
                st.collision});
            finish_txn(1'b1);
        end
        m.start();
        m.idle();
        tick(8);
        chk("bus error", 8'h01, {7'h00, st.bus_error});
        finish_txn(1'b0);
        chk("pin outs", 8'h00, {6'h00, scl_o, sda_o});
        chk("stalls", 8'h00, 8'(m.stalls));
        give_verdict();
    end
endmodule : tb

// >>> two_wire_link_shift.sv
/*
 * Link-side receive shifter, clocked by SCL itself.
 * Assumes the system side reads the byte only while SCL is low after the eighth rise,
 * when no further SCL edge can disturb it.
 */
`timescale 1ns/1ps
module two_wire_link_shift (
    input wire logic scl_clk_in,
    input wire logic sda_in,
    output logic [7:0] byte_out
);
    logic [7:0] shift_q;

    // msb arrives first, one bit per rising scl
    always_ff @(posedge scl_clk_in) begin
        shift_q <= {shift_q[6:0], sda_in};
    end

    assign byte_out = shift_q;

endmodule : two_wire_link_shift

// >>> two_wire_master_model.sv
/* bus master model for the two-wire slave bench, timed by a free 15 ns timebase.
   assumes the bench resolves both lines as wired-and with pull-ups. */
`timescale 1ns/1ps
module two_wire_master_model (
    input wire logic link_clk_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_drv_out,
    output logic sda_drv_out
);
    int stalls = 0;
    initial begin
        scl_drv_out = 1'b1;
        sda_drv_out = 1'b1;
    end
    task automatic ticks(input int n);
        repeat (n) @(posedge link_clk_in);
    endtask : ticks
    // sda moves four ticks into the sixteen-tick low phase, away from scl edges, so no false start or stop
    task automatic clk_bit(input logic b, output logic s);
        int n;
        scl_drv_out = 1'b0;
        ticks(4);
        sda_drv_out = b;
        ticks(12);
        scl_drv_out = 1'b1;
        for (n = 0; n < 4000 && scl_in !== 1'b1; n++) ticks(1);
        if (scl_in !== 1'b1) stalls++;
        ticks(8);
        s = sda_in;
        ticks(8);
    endtask : clk_bit
    task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
                        output logic ao);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(tx[i], s);
            rx[i] = s;
        end
        clk_bit(ai, ao);
    endtask : xfer
    task automatic start;
        sda_drv_out = 1'b0;
        ticks(16);
    endtask : start
    task automatic idle;
        sda_drv_out = 1'b1;
        ticks(16);
    endtask : idle
    task automatic stop;
        logic s;
        clk_bit(1'b0, s);
        idle();
    endtask : stop
    // sda rises in a low phase, so only the following fall under high scl counts
    task automatic restart;
        logic s;
        clk_bit(1'b1, s);
        start();
    endtask : restart
endmodule : two_wire_master_model

// >>> two_wire_slave_interface.sv
/*
 * Slave-only two-wire interface controller: start/stop detection, address match,
 * byte receive and transmit, clock stretching and status flags.
 * Assumes open-drain pads resolved outside and software driving the plain control ports.
 */
// Functional notes
// - scl is pulled low only after it has been seen low
// - start during sleep holds scl low through the wake-up interval
// - no bus timeout detection; a stuck bus stays stuck
// - byte oriented with separate data and address/stop flags
// - either flag set keeps scl held low until serviced
// - status shows ack received, clock hold, collision, bus error, direction
// - promiscuous mode accepts every address
// - after start shift and compare address; ack match, else idle to start
// - address/stop flag on matching address or general call
// - start directly followed by stop sets bus error
// - direction flag captures r/w bit of last matching address
// - read address: stretch, after ack raise data flag, after nack idle
// - write address: stretch, after ack await data, after nack idle
// - failed high or nack on sda: collision, release drivers and scl
// - stop after a matched address sets address/stop flag marked as caused by stop
// - each received byte sets data flag; after nack expect only stop/start
// - read data starts on data write; flag per byte; nack ends sending
// - packets are eight bits msb first plus acknowledge on ninth clock
// - valid command releases scl, clears clock hold and both flags
// - flags clear on writing one; zero leaves them alone
`timescale 1ns/1ps
module two_wire_slave_interface (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic scl_clk_in,
    input wire logic sda_in,
    input wire two_wire_slave_pkg::ctrl_t ctrl_in,
    input wire two_wire_slave_pkg::clr_t clr_in,
    input wire logic sleep_in,
    input wire logic cmd_valid_in,
    input wire logic [1:0] slave_command_field_in,
    input wire logic data_write_in,
    input wire logic [7:0] slave_data_register_in,
    output two_wire_slave_pkg::status_t status_out,
    output logic [7:0] rx_data_out,
    output logic scl_out,
    output logic scl_oe_out,
    output logic sda_out,
    output logic sda_oe_out
);
    // ------------------------------------------------------------
    // pin synchronisers and bus conditions
    // ------------------------------------------------------------
    logic [2:0] scl_sy_q;
    logic [2:0] sda_sy_q;
    logic scl_f_q;
    logic sda_f_q;
    logic [7:0] link_byte;
    wire scl_nx = (scl_sy_q[1] == scl_sy_q[2]) ? scl_sy_q[2] : scl_f_q;
    wire sda_nx = (sda_sy_q[1] == sda_sy_q[2]) ? sda_sy_q[2] : sda_f_q;

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            scl_sy_q <= two_wire_slave_pkg::SYNC_RST;
            sda_sy_q <= two_wire_slave_pkg::SYNC_RST;
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
        end else begin
            scl_sy_q <= {scl_sy_q[1:0], scl_clk_in};
            sda_sy_q <= {sda_sy_q[1:0], sda_in};
            scl_f_q <= scl_nx;
            sda_f_q <= sda_nx;
        end
    end

    wire scl_rise = scl_nx & ~scl_f_q;
    wire scl_fall = ~scl_nx & scl_f_q;
    wire start_ev = scl_f_q & scl_nx & sda_f_q & ~sda_nx;
    wire stop_ev = scl_f_q & scl_nx & ~sda_f_q & sda_nx;

    two_wire_link_shift link_shift (
        .scl_clk_in(scl_clk_in),
        .sda_in(sda_in),
        .byte_out(link_byte)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    two_wire_slave_pkg::state_t st_q;
    two_wire_slave_pkg::state_t st_d;
    two_wire_slave_pkg::state_t nxt_q;
    two_wire_slave_pkg::state_t nxt_d;
    two_wire_slave_pkg::status_t status_q;
    logic [3:0] bcnt_q;
    logic [3:0] bcnt_d;
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic [7:0] rx_q;
    logic sda_oe_q;
    logic sda_oe_d;
    logic scl_oe_q;
    logic addressed_q;
    logic [two_wire_slave_pkg::WAKE_W-1:0] wake_q;
    logic data_set;
    logic ack_start;

    wire en = ctrl_in.enable;
    wire byte_end = scl_fall & (bcnt_q == two_wire_slave_pkg::LAST_BIT);
    wire addr_done = en & (st_q == two_wire_slave_pkg::st_addr) & byte_end;
    wire gen_call = (link_byte[7:1] == two_wire_slave_pkg::GEN_CALL_ADDR) & ~link_byte[0];
    wire own_hit = link_byte[7:1] == ctrl_in.own_addr;
    wire addr_match = ctrl_in.promisc | own_hit | gen_call;
    wire flags_on = status_q.data_event_flag | status_q.address_stop_event_flag;
    wire cmd_go = cmd_valid_in & slave_command_field_in[1] & flags_on;
    wire cmd_next = slave_command_field_in == two_wire_slave_pkg::CMD_NEXT;
    wire drv_state = (st_q == two_wire_slave_pkg::st_tx) | (st_q == two_wire_slave_pkg::st_ack);
    // released sda seen low at the sampling edge means another driver won
    wire coll_ev = en & scl_rise & drv_state & ~sda_oe_q & ~sda_f_q;
    wire berr_ev = en & stop_ev & (st_q == two_wire_slave_pkg::st_addr)
        & (bcnt_q == 4'h0);
    wire stop_flag_ev = en & stop_ev & ctrl_in.stop_ie & addressed_q;
    wire tx_go = en & data_write_in & (st_q == two_wire_slave_pkg::st_tx_wait);
    wire nack_plan = ctrl_in.ack_action;
    wire rx_end = (st_q == two_wire_slave_pkg::st_rx) & byte_end;
    wire data_clr = clr_in.data_flag | cmd_go | tx_go;
    wire as_clr = clr_in.addr_stop_flag | cmd_go;
    wire as_set = (addr_done & addr_match) | stop_flag_ev;
    wire wake_hold = wake_q != '0;
    // no bus timeout is kept: a master that stalls mid-byte leaves the bus stuck

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        nxt_d = nxt_q;
        bcnt_d = bcnt_q;
        tx_d = tx_q;
        sda_oe_d = sda_oe_q;
        data_set = 1'b0;
        ack_start = 1'b0;
        if (scl_rise && st_q inside {two_wire_slave_pkg::st_addr, two_wire_slave_pkg::st_rx,
                two_wire_slave_pkg::st_tx}) begin
            bcnt_d = bcnt_q + 4'h1;
        end
        if (!en) begin
            st_d = two_wire_slave_pkg::st_idle;
            sda_oe_d = 1'b0;
        end else if (start_ev) begin
            // repeated start is accepted from any state, even after a collision
            st_d = two_wire_slave_pkg::st_addr;
            bcnt_d = 4'h0;
            sda_oe_d = 1'b0;
        end else if (stop_ev || coll_ev) begin
            st_d = two_wire_slave_pkg::st_idle;
            sda_oe_d = 1'b0;
        end else begin
            case (st_q)
                two_wire_slave_pkg::st_addr: begin
                    if (byte_end) begin
                        // mismatch leaves the ack slot released
                        st_d = addr_match ? two_wire_slave_pkg::st_addr_hold
                            : two_wire_slave_pkg::st_idle;
                    end
                end
                two_wire_slave_pkg::st_addr_hold: begin
                    if (cmd_go && (cmd_next || !status_q.dir_read)) begin
                        ack_start = 1'b1;
                        if (nack_plan || !cmd_next) begin
                            nxt_d = two_wire_slave_pkg::st_idle;
                        end else if (status_q.dir_read) begin
                            nxt_d = two_wire_slave_pkg::st_tx_wait;
                        end else begin
                            nxt_d = two_wire_slave_pkg::st_rx;
                        end
                    end else if (cmd_go) begin
                        st_d = two_wire_slave_pkg::st_idle;
                    end
                end
                two_wire_slave_pkg::st_rx_hold: begin
                    if (cmd_go) begin
                        ack_start = 1'b1;
                        // after a nack only stop or repeated start may follow
                        nxt_d = (cmd_next && !nack_plan) ? two_wire_slave_pkg::st_rx
                            : two_wire_slave_pkg::st_idle;
                    end
                end
                two_wire_slave_pkg::st_ack: begin
                    if (scl_fall) begin
                        st_d = nxt_q;
                        sda_oe_d = 1'b0;
                        bcnt_d = 4'h0;
                        data_set = nxt_q == two_wire_slave_pkg::st_tx_wait;
                    end
                end
                two_wire_slave_pkg::st_rx: begin
                    if (byte_end) begin
                        st_d = two_wire_slave_pkg::st_rx_hold;
                        data_set = 1'b1;
                    end
                end
                two_wire_slave_pkg::st_tx_wait: begin
                    if (tx_go) begin
                        st_d = two_wire_slave_pkg::st_tx;
                        tx_d = slave_data_register_in;
                        sda_oe_d = ~slave_data_register_in[7];
                        bcnt_d = 4'h0;
                    end else if (cmd_go && !cmd_next) begin
                        st_d = two_wire_slave_pkg::st_idle;
                    end
                end
                two_wire_slave_pkg::st_tx: begin
                    if (byte_end) begin
                        st_d = two_wire_slave_pkg::st_tx_ack;
                        sda_oe_d = 1'b0;
                    end else if (scl_fall) begin
                        tx_d = {tx_q[6:0], 1'b0};
                        sda_oe_d = ~tx_q[6];
                    end
                end
                two_wire_slave_pkg::st_tx_ack: begin
                    if (scl_fall) begin
                        bcnt_d = 4'h0;
                        // master nack ends the read
                        st_d = status_q.rx_nack ? two_wire_slave_pkg::st_idle
                            : two_wire_slave_pkg::st_tx_wait;
                        data_set = ~status_q.rx_nack;
                    end
                end
                default: begin
                    st_d = st_q;
                end
            endcase
            if (ack_start) begin
                st_d = two_wire_slave_pkg::st_ack;
                sda_oe_d = ~nack_plan;
            end
        end
    end

    // stretch only once scl is already low; masters then wait on us
    wire scl_oe_d = en & (flags_on | wake_hold) & (~scl_f_q | scl_oe_q);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            st_q <= two_wire_slave_pkg::st_idle;
            nxt_q <= two_wire_slave_pkg::st_idle;
            bcnt_q <= 4'h0;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
            addressed_q <= 1'b0;
        end else begin
            st_q <= st_d;
            nxt_q <= nxt_d;
            bcnt_q <= bcnt_d;
            tx_q <= tx_d;
            sda_oe_q <= sda_oe_d;
            scl_oe_q <= scl_oe_d;
            if (rx_end) begin
                rx_q <= link_byte;
            end
            if (stop_ev) begin
                addressed_q <= 1'b0;
            end else if (addr_done && addr_match) begin
                addressed_q <= 1'b1;
            end
        end
    end

    // sleep wake-up: count only while we really hold the line
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            wake_q <= '0;
        end else if (en && start_ev && sleep_in) begin
            wake_q <= two_wire_slave_pkg::WAKE_W'(two_wire_slave_pkg::WAKE_CYC);
        end else if (wake_hold && scl_oe_q) begin
            wake_q <= wake_q - 1'b1;
        end
    end

    // ------------------------------------------------------------
    // status, set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            status_q <= two_wire_slave_pkg::STATUS_RST;
        end else begin
            status_q.data_event_flag <= data_set | (status_q.data_event_flag & ~data_clr);
            status_q.address_stop_event_flag <= as_set
                | (status_q.address_stop_event_flag & ~as_clr);
            status_q.clock_hold_indicator <= scl_oe_d;
            status_q.collision <= coll_ev | (status_q.collision & ~clr_in.collision);
            status_q.bus_error <= berr_ev | (status_q.bus_error & ~clr_in.bus_error);
            if (st_q == two_wire_slave_pkg::st_tx_ack && scl_rise) begin
                status_q.rx_nack <= sda_f_q;
            end
            if (addr_done && addr_match) begin
                status_q.dir_read <= link_byte[0];
                status_q.by_stop <= 1'b0;
            end else if (stop_flag_ev) begin
                status_q.by_stop <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

    assign status_out = status_q;
    assign rx_data_out = rx_q;
    assign scl_oe_out = scl_oe_q;
    assign sda_oe_out = sda_oe_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_addr_hit;
        addr_done && addr_match;
    endsequence

    sequence s_held;
        en && flags_on && !scl_f_q;
    endsequence

    chk_hold_flags: assert property (s_held ##1 en && flags_on |-> scl_oe_q)
        else $error("flag pending but scl not held");
    chk_low_first: assert property ($rose(scl_oe_q) |-> !$past(scl_f_q))
        else $error("scl driven before seen low");
    chk_cmd_release: assert property (cmd_go && scl_oe_q |=> !flags_on ##1 !scl_oe_q)
        else $error("command did not release scl");
    chk_addr_flag: assert property (s_addr_hit |=> status_q.address_stop_event_flag
        && !status_q.by_stop && st_q == two_wire_slave_pkg::st_addr_hold)
        else $error("address match did not raise flag");
    chk_dir_capture: assert property (s_addr_hit |=> status_q.dir_read == $past(link_byte[0]))
        else $error("direction not captured");
    chk_nomatch_idle: assert property (addr_done && !addr_match |=> st_q
        == two_wire_slave_pkg::st_idle && !sda_oe_q)
        else $error("mismatch not ignored");
    chk_bus_error: assert property (berr_ev |=> status_q.bus_error)
        else $error("start-stop did not flag bus error");
    chk_collision: assert property (coll_ev |=> status_q.collision && !sda_oe_q
        && st_q == two_wire_slave_pkg::st_idle)
        else $error("collision not handled");
    chk_stop_flag: assert property (stop_flag_ev |=> status_q.address_stop_event_flag
        && status_q.by_stop)
        else $error("stop not flagged");
    chk_wake_hold: assert property ($rose(scl_oe_q) && wake_hold |=> scl_oe_q [*4])
        else $error("wake-up hold too short");

endmodule : two_wire_slave_interface

// >>> two_wire_slave_pkg.sv
/*
 * Shared types and constants of the two-wire slave controller.
 * Assumes a 40 MHz system clock and an I2C bus whose SCL doubles as the link clock.
 */
package two_wire_slave_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int WAKE_NS = 100;
    localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_W = 4;

    // ------------------------------------------------------------
    // packet layout
    // ------------------------------------------------------------
    localparam int BYTE_BITS = 8;
    localparam logic [3:0] LAST_BIT = 4'h8;
    localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
    localparam logic [1:0] CMD_DONE = 2'h2;
    localparam logic [1:0] CMD_NEXT = 2'h3;
    localparam logic [2:0] SYNC_RST = 3'h7;

    typedef enum logic [3:0] {
        st_idle,
        st_addr,
        st_addr_hold,
        st_ack,
        st_rx,
        st_rx_hold,
        st_tx_wait,
        st_tx,
        st_tx_ack
    } state_t;

    // software controls, ack_action high means answer with not-acknowledge
    typedef struct packed {
        logic enable;
        logic promisc;
        logic stop_ie;
        logic ack_action;
        logic [6:0] own_addr;
    } ctrl_t;

    // write-one-to-clear strobes
    typedef struct packed {
        logic data_flag;
        logic addr_stop_flag;
        logic collision;
        logic bus_error;
    } clr_t;

    typedef struct packed {
        logic data_event_flag;
        logic address_stop_event_flag;
        logic clock_hold_indicator;
        logic rx_nack;
        logic collision;
        logic bus_error;
        logic dir_read;
        logic by_stop;
    } status_t;

    localparam status_t STATUS_RST = '0;

endpackage : two_wire_slave_pkg
